// file: core/adcs_defines.svh
`ifndef ADCS_DEFINES_SVH
`define ADCS_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADCS_CTRL0_OFS     8'h1e
`define ADCS_CTRL1_OFS     8'h1f
`define ADCS_STATUS_OFS    8'h20
`define ADCS_IRQ_CLR_OFS   8'h21
`define ADCS_IRQ_EN_OFS    8'h22
`define ADCS_RES_HI_NIB    4'h3

// ----------------------------------------------------------------
// control register zero fields
// ----------------------------------------------------------------
`define ADCS_C0_CHSEL_LSB  0
`define ADCS_C0_CHSEL_MSB  2
`define ADCS_C0_MODE_LSB   3
`define ADCS_C0_MODE_MSB   4
`define ADCS_C0_TRIG_BIT   5
`define ADCS_C0_START_BIT  6
`define ADCS_C0_DIV2_BIT   7
`define ADCS_C0_RESET      8'h00

// ----------------------------------------------------------------
// control register one fields
// ----------------------------------------------------------------
`define ADCS_C1_SWEEP_LSB  0
`define ADCS_C1_SWEEP_MSB  1
`define ADCS_C1_RES10_BIT  3
`define ADCS_C1_LADDER_BIT 5
`define ADCS_C1_WMASK      8'h3b
`define ADCS_C1_RESET      8'h03

// ----------------------------------------------------------------
// status bits and misc
// ----------------------------------------------------------------
`define ADCS_ST_PIN_DONE   0
`define ADCS_ST_SEQ_END    1
`define ADCS_ST_EXT_TRIG   2
`define ADCS_ST_RESET      3'h0
`define ADCS_AIN_ALL       8'hff
`define ADCS_AIN_NO_TRIG   8'hdf
`define ADCS_TRIG_CHAN     3'h5

// ----------------------------------------------------------------
// timing, lengths in converter clock cycles, divider last counts in mclk cycles
// ----------------------------------------------------------------
`define ADCS_CYC8          6'd49
`define ADCS_CYC10         6'd59
`define ADCS_DIV4_LAST     2'h3
`define ADCS_DIV2_LAST     2'h1

`endif

// file: core/adcs_pkg.sv
package adcs_pkg;

  typedef enum logic [1:0] {
    ADCS_IDLE = 2'b01,
    ADCS_CONV = 2'b10
  } adcs_state_e;

  typedef enum logic [1:0] {
    ADCS_ONE_SHOT     = 2'b00,
    ADCS_REPEAT       = 2'b01,
    ADCS_SINGLE_SWEEP = 2'b10,
    ADCS_REPEAT_SWEEP = 2'b11
  } adcs_mode_e;

endpackage

// file: core/adcs_clkdiv.sv
`timescale 1ns/1ps
`include "adcs_defines.svh"

module adcs_clkdiv (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic run_i,
  input  wire logic div2_i,
  output logic      tick_o
);
  import adcs_pkg::*;

  logic [1:0] cnt_r;
  logic [1:0] last;

  // ----------------------------------------------------------------
  // converter clock enable
  // ----------------------------------------------------------------
  assign last = div2_i ? `ADCS_DIV2_LAST : `ADCS_DIV4_LAST;

  // restarts on each run so the first edge is a whole period away
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 2'h0;
    end else if (!run_i || cnt_r >= last) begin
      cnt_r <= 2'h0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= run_i && (cnt_r == last - 2'h1);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // rate must be steady over the window, a mid-run switch reshapes one gap
  sequence hold4_s;
    (run_i && !div2_i) [*4];
  endsequence

  div_four_a: assert property (
    (tick_o && run_i && !div2_i && !$past(div2_i)) ##1 hold4_s
      |-> tick_o && !$past(tick_o, 1) && !$past(tick_o, 2) && !$past(tick_o, 3))
    else $error("divide by four spacing wrong");
  div_two_a: assert property (
    (tick_o && run_i && div2_i) ##1 (run_i && div2_i) |-> !tick_o ##1 tick_o)
    else $error("divide by two spacing wrong");

endmodule // adcs_clkdiv

// file: core/adcs_seq_ctrl.sv
// Notes on behaviour
// - internal source: writing start one triggers conversion
// - writing start zero halts converter, either source
// - internal single modes: hardware clears start when done
// - external single modes: start stays one when done
// - repeat modes run until software clears start
// - external source, start one: falling pin edge triggers
// - trigger source bit picks flag or pin
// - clock select: divide by four or two
// - sweep field scans 2/4/6/8 inputs from zero
// - resolution bit: zero eight bits, one ten
// - ladder bit one disconnects reference, reset connected
// - external source: input five skipped in sweeps, never stored
// - pin conversion takes 49 or 59 cycles
// - mode field: one-shot, repeat, sweep, repeat sweep
// - result stored in that pin's own register
`timescale 1ns/1ps
`include "adcs_defines.svh"

module adcs_seq_ctrl (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rd_data_o,
  input  wire logic       ext_trigger_pin_i,
  input  wire logic [9:0] sar_result_i,
  output logic            busy_o,
  output logic      [2:0] chan_o,
  output logic            res10_o,
  output logic            ladder_en_o,
  output logic      [7:0] ain_en_o,
  output logic            irq_o
);
  import adcs_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  adcs_state_e state_r;
  adcs_mode_e  mode;
  logic [7:0]  ctrl0_r;
  logic [7:0]  ctrl1_r;
  logic [7:0]  eff_c0;
  logic [2:0]  status_r;
  logic [2:0]  status_nxt;
  logic [2:0]  irq_en_r;
  logic [2:0]  chan_r;
  logic [2:0]  nxt_ch;
  logic [2:0]  last_ch;
  logic [5:0]  cyc_r;
  logic [5:0]  len_m1;
  logic [7:0]  pin_cyc_r;
  logic [9:0]  result_r [0:7];
  logic [7:0]  rd_mux;
  logic        trig_s1_r;
  logic        trig_s2_r;
  logic        trig_prev_r;
  logic        wr_c0;
  logic        wr_c1;
  logic        sw_trig;
  logic        sw_stop;
  logic        ext_trig;
  logic        trigger;
  logic        idle;
  logic        tick;
  logic        done_p;
  logic        sweep_end;
  logic        seq_end;
  logic        store_ok;

  assign mode   = adcs_mode_e'(ctrl0_r[`ADCS_C0_MODE_MSB:`ADCS_C0_MODE_LSB]);
  assign idle   = (state_r == ADCS_IDLE);
  assign wr_c0  = wr_i && (addr_i == `ADCS_CTRL0_OFS);
  assign wr_c1  = wr_i && (addr_i == `ADCS_CTRL1_OFS);
  assign eff_c0 = wr_c0 ? wdata_i : ctrl0_r;

  // ----------------------------------------------------------------
  // trigger pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      trig_s1_r   <= 1'b1;
      trig_s2_r   <= 1'b1;
      trig_prev_r <= 1'b1;
    end else begin
      trig_s1_r   <= ext_trigger_pin_i;
      trig_s2_r   <= trig_s1_r;
      trig_prev_r <= trig_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // trigger decode
  // ----------------------------------------------------------------
  // write of one with the internal source chosen in the same data
  assign sw_trig  = wr_c0 && wdata_i[`ADCS_C0_START_BIT]
                    && !wdata_i[`ADCS_C0_TRIG_BIT];
  assign sw_stop  = wr_c0 && !wdata_i[`ADCS_C0_START_BIT];
  // a write to control zero masks the pin for that cycle
  assign ext_trig = ctrl0_r[`ADCS_C0_TRIG_BIT] && ctrl0_r[`ADCS_C0_START_BIT]
                    && trig_prev_r && !trig_s2_r && !wr_c0;
  assign trigger  = idle && (sw_trig || ext_trig);

  // ----------------------------------------------------------------
  // conversion timing
  // ----------------------------------------------------------------
  adcs_clkdiv i_adcs_clkdiv (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .run_i  (state_r == ADCS_CONV),
    .div2_i (ctrl0_r[`ADCS_C0_DIV2_BIT]),
    .tick_o (tick)
  );

  assign len_m1 = ctrl1_r[`ADCS_C1_RES10_BIT] ? (`ADCS_CYC10 - 6'd1)
                                             : (`ADCS_CYC8 - 6'd1);
  assign done_p = (state_r == ADCS_CONV) && tick && (cyc_r == len_m1) && !sw_stop;

  // ----------------------------------------------------------------
  // channel sequencing
  // ----------------------------------------------------------------
  assign last_ch = {ctrl1_r[`ADCS_C1_SWEEP_MSB:`ADCS_C1_SWEEP_LSB], 1'b1};
  // the trigger pin shares input five, so sweeps hop over it when the external source is chosen
  always_comb begin
    nxt_ch = chan_r + 3'd1;
    if (ctrl0_r[`ADCS_C0_TRIG_BIT] && nxt_ch == `ADCS_TRIG_CHAN) begin
      nxt_ch = 3'd6;
    end
  end
  assign sweep_end = (chan_r == last_ch) || (ctrl0_r[`ADCS_C0_TRIG_BIT]
                     && chan_r == 3'd4 && last_ch == `ADCS_TRIG_CHAN);
  assign seq_end   = done_p && !mode[0] && (!mode[1] || sweep_end);
  assign store_ok  = !(ctrl0_r[`ADCS_C0_TRIG_BIT] && chan_r == `ADCS_TRIG_CHAN);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ADCS_IDLE;
      chan_r  <= 3'h0;
    end else if (sw_stop) begin
      state_r <= ADCS_IDLE;
    end else if (trigger) begin
      state_r <= ADCS_CONV;
      chan_r  <= eff_c0[`ADCS_C0_MODE_MSB] ? 3'h0
                 : eff_c0[`ADCS_C0_CHSEL_MSB:`ADCS_C0_CHSEL_LSB];
    end else if (done_p) begin
      if (seq_end) begin
        state_r <= ADCS_IDLE;
      end else if (mode[1]) begin
        chan_r <= sweep_end ? 3'h0 : nxt_ch;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cyc_r <= 6'h0;
    end else if (state_r != ADCS_CONV || done_p) begin
      cyc_r <= 6'h0;
    end else if (tick) begin
      cyc_r <= cyc_r + 6'd1;
    end
  end

  // mclk cycles spent on the pin in hand; only the length check reads it
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_cyc_r <= 8'h0;
    end else if (state_r != ADCS_CONV || done_p) begin
      pin_cyc_r <= 8'h0;
    end else begin
      pin_cyc_r <= pin_cyc_r + 8'd1;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // a software write wins over the self clear in the same cycle
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl0_r <= `ADCS_C0_RESET;
    end else if (wr_c0) begin
      ctrl0_r <= wdata_i;
    end else if (seq_end && !ctrl0_r[`ADCS_C0_TRIG_BIT]) begin
      ctrl0_r[`ADCS_C0_START_BIT] <= 1'b0;
    end
  end

  // no lockout while busy; software keeps to the stopped-only window
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl1_r <= `ADCS_C1_RESET;
    end else if (wr_c1) begin
      ctrl1_r <= wdata_i & `ADCS_C1_WMASK;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ladder_en_o <= 1'b1;
      res10_o     <= 1'b0;
      ain_en_o    <= `ADCS_AIN_ALL;
      busy_o      <= 1'b0;
      chan_o      <= 3'h0;
    end else begin
      ladder_en_o <= !ctrl1_r[`ADCS_C1_LADDER_BIT];
      res10_o     <= ctrl1_r[`ADCS_C1_RES10_BIT];
      ain_en_o    <= ctrl0_r[`ADCS_C0_TRIG_BIT] ? `ADCS_AIN_NO_TRIG
                                                : `ADCS_AIN_ALL;
      busy_o      <= (state_r == ADCS_CONV);
      chan_o      <= chan_r;
    end
  end

  // ----------------------------------------------------------------
  // result registers
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 8; g++) begin : g_res
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        result_r[g] <= 10'h000;
      end else if (done_p && store_ok && chan_r == 3'(g)) begin
        result_r[g] <= sar_result_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  always_comb begin
    status_nxt = status_r;
    if (wr_i && addr_i == `ADCS_IRQ_CLR_OFS) begin
      status_nxt = status_nxt & ~wdata_i[2:0];
    end
    // set after clear so an event in the clear cycle survives
    status_nxt[`ADCS_ST_PIN_DONE] = status_nxt[`ADCS_ST_PIN_DONE] | (done_p && store_ok);
    status_nxt[`ADCS_ST_SEQ_END]  = status_nxt[`ADCS_ST_SEQ_END] | seq_end;
    status_nxt[`ADCS_ST_EXT_TRIG] = status_nxt[`ADCS_ST_EXT_TRIG] | (idle && ext_trig);
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      status_r <= `ADCS_ST_RESET;
      irq_en_r <= 3'h0;
      irq_o    <= 1'b0;
    end else begin
      status_r <= status_nxt;
      if (wr_i && addr_i == `ADCS_IRQ_EN_OFS) begin
        irq_en_r <= wdata_i[2:0];
      end
      irq_o <= |(status_nxt & ((wr_i && addr_i == `ADCS_IRQ_EN_OFS) ? wdata_i[2:0]
                                                                     : irq_en_r));
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 8'h00;
    if (addr_i[7:4] == `ADCS_RES_HI_NIB) begin
      rd_mux = addr_i[0] ? {6'h00, result_r[addr_i[3:1]][9:8]}
                         : result_r[addr_i[3:1]][7:0];
    end else begin
      case (addr_i)
        `ADCS_CTRL0_OFS:  rd_mux = ctrl0_r;
        `ADCS_CTRL1_OFS:  rd_mux = ctrl1_r;
        `ADCS_STATUS_OFS: rd_mux = {5'h00, status_r};
        `ADCS_IRQ_EN_OFS: rd_mux = {5'h00, irq_en_r};
        default:          rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= 8'h00;
    end else begin
      rd_data_o <= rd_i ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence single_done_s;
    done_p && seq_end && !wr_c0;
  endsequence

  conv_length_a: assert property (
    done_p |-> pin_cyc_r + 8'd1 == (ctrl0_r[7] ? 8'd2 : 8'd4)
               * (ctrl1_r[3] ? 8'(`ADCS_CYC10) : 8'(`ADCS_CYC8)))
    else $error("conversion length wrong");
  int_start_a: assert property (
    (idle && sw_trig) |=> busy_o == 1'b0 ##1 busy_o)
    else $error("software start did not begin conversion");
  stop_write_a: assert property (
    sw_stop |=> idle ##1 !busy_o)
    else $error("stop write did not halt");
  self_clear_a: assert property (
    single_done_s ##0 !ctrl0_r[5] |=> !ctrl0_r[6] && idle)
    else $error("start flag not cleared");
  ext_keep_a: assert property (
    single_done_s ##0 ctrl0_r[5] |=> ctrl0_r[6] && idle)
    else $error("start flag lost after external run");
  repeat_run_a: assert property (
    (done_p && mode[0] && !wr_c0) |=> state_r == ADCS_CONV && cyc_r == 6'h0)
    else $error("repeat mode stopped");
  ext_start_a: assert property (
    (idle && ext_trig) |=> state_r == ADCS_CONV && status_r[2])
    else $error("pin edge did not start");
  sweep_origin_a: assert property (
    (trigger && eff_c0[4]) |=> chan_r == 3'h0)
    else $error("sweep not from input zero");
  skip_five_a: assert property (
    (ctrl0_r[5] && mode[1] && state_r == ADCS_CONV) |-> chan_r != 3'h5)
    else $error("input five converted under pin trigger");
  store_pin_a: assert property (
    (done_p && store_ok) |=> result_r[$past(chan_r)] == $past(sar_result_i))
    else $error("result not stored");
  ladder_off_a: assert property (
    (wr_c1 && wdata_i[5]) |=> ##1 !ladder_en_o)
    else $error("ladder not disconnected");

endmodule // adcs_seq_ctrl

// file: testbench/adcs_seq_ctrl_test.sv
`timescale 1ns/1ps
`include "adcs_defines.svh"

module adcs_seq_ctrl_test;
  import adcs_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int SETTLE_CYC = 8; // ladder settling, arbitrary guess
  logic        mclk_i            = 1'b0;
  logic        rst_i             = 1'b1;
  logic [7:0]  addr_i            = 8'h00;
  logic [7:0]  wdata_i           = 8'h00;
  logic        wr_i              = 1'b0;
  logic        rd_i              = 1'b0;
  logic        ext_trigger_pin_i = 1'b1;
  logic [9:0]  sar_result_i      = 10'h000;
  logic [7:0]  rd_data_o;
  logic        busy_o;
  logic [2:0]  chan_o;
  logic        res10_o;
  logic        ladder_en_o;
  logic [7:0]  ain_en_o;
  logic        irq_o;
  logic        rd_seen           = 1'b0;
  logic [7:0]  exp_q[$];
  logic [31:0] seed              = 32'd76;
  int          fails             = 0;
  int          checks_done       = 0;

  adcs_seq_ctrl i_adcs_seq_ctrl (
    .mclk_i            (mclk_i),
    .rst_i             (rst_i),
    .addr_i            (addr_i),
    .wdata_i           (wdata_i),
    .wr_i              (wr_i),
    .rd_i              (rd_i),
    .rd_data_o         (rd_data_o),
    .ext_trigger_pin_i (ext_trigger_pin_i),
    .sar_result_i      (sar_result_i),
    .busy_o            (busy_o),
    .chan_o            (chan_o),
    .res10_o           (res10_o),
    .ladder_en_o       (ladder_en_o),
    .ain_en_o          (ain_en_o),
    .irq_o             (irq_o)
  );

  always #25 mclk_i = ~mclk_i;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
  endtask

  // expected data noted here, compared by the watcher two cycles later
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    exp_q.push_back(e);
    @(posedge mclk_i);
    rd_i   <= 1'b0;
  endtask

  task automatic wait_busy(input logic lvl, input int lim, output int n);
    n = 0;
    while (busy_o !== lvl) begin
      @(posedge mclk_i);
      n++;
      if (n > lim) begin
        fails++;
        $display("wrong value busy expected %b seen timeout", lvl);
        final_report();
      end
    end
  endtask

  // internal one-shot with a random result held on the datapath
  task automatic conv(input logic [7:0] c0, input int len);
    int         n;
    logic [9:0] r;
    seed = xs(seed);
    r = seed[9:0];
    sar_result_i <= r;
    wr(`ADCS_CTRL0_OFS, c0);
    wait_busy(1'b1, 8, n);
    chk8("channel", {5'h0, c0[2:0]}, {5'h0, chan_o});
    wait_busy(1'b0, 800, n);
    chk1("conv length", 1'b1, n >= len - 1 && n <= len + 1);
    rd(`ADCS_CTRL0_OFS, c0 & 8'hbf);
    rd({`ADCS_RES_HI_NIB, c0[2:0], 1'b0}, r[7:0]);
    rd({`ADCS_RES_HI_NIB, c0[2:0], 1'b1}, {6'h0, r[9:8]});
    rd(`ADCS_STATUS_OFS, 8'h03);
  endtask

  // ----------------------------------------------------------------
  // read data watcher
  // ----------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (rd_seen) begin
      if (exp_q.size() == 0)
        chk8("unexpected read", 8'h00, 8'hff);
      else
        chk8("read data", exp_q.pop_front(), rd_data_o);
    end
    rd_seen <= rd_i;
  end

  // ----------------------------------------------------------------
  // main sequence; ctrl1 only written while stopped
  // ----------------------------------------------------------------
  initial begin
    int         n;
    logic [2:0] mx;
    logic [2:0] ch;
    tick(3);
    rst_i <= 1'b0;
    tick(1);
    chk1("ladder", 1'b1, ladder_en_o);
    chk1("res10", 1'b0, res10_o);
    chk8("ain enable", 8'hff, ain_en_o);
    chk1("busy", 1'b0, busy_o);
    chk1("irq", 1'b0, irq_o);
    rd(`ADCS_CTRL0_OFS, 8'h00);
    rd(`ADCS_CTRL1_OFS, 8'h03);
    rd(`ADCS_STATUS_OFS, 8'h00);
    rd(`ADCS_IRQ_EN_OFS, 8'h00);
    rd(`ADCS_IRQ_CLR_OFS, 8'h00);
    rd(8'h10, 8'h00);
    wr(`ADCS_CTRL1_OFS, 8'hff);
    rd(`ADCS_CTRL1_OFS, 8'h3b);
    tick(2);
    chk1("res10", 1'b1, res10_o);
    chk1("ladder", 1'b0, ladder_en_o);
    wr(`ADCS_CTRL1_OFS, 8'h03);
    tick(SETTLE_CYC);
    chk1("ladder", 1'b1, ladder_en_o);
    // both clock rates and both resolutions; one one-shot for each pair
    for (int i = 0; i < 4; i++) begin
      wr(`ADCS_CTRL1_OFS, {4'h0, i[0], 3'h3});
      seed = xs(seed);
      ch = seed[5:3];
      conv({i[1], 2'b10, ADCS_ONE_SHOT, ch}, (i[0] ? 59 : 49) * (i[1] ? 2 : 4));
      chk1("irq masked", i > 0, irq_o);
      wr(`ADCS_IRQ_EN_OFS, 8'h03);
      tick(2);
      chk1("irq", 1'b1, irq_o);
      wr(`ADCS_IRQ_CLR_OFS, 8'h03);
      tick(2);
      chk1("irq", 1'b0, irq_o);
    end
    rd(`ADCS_IRQ_EN_OFS, 8'h03);
    rd(`ADCS_STATUS_OFS, 8'h00);
    // external source: nothing until the pin falls
    wr(`ADCS_CTRL0_OFS, {1'b1, 1'b1, 1'b1, ADCS_ONE_SHOT, 3'h2});
    tick(20);
    chk1("busy", 1'b0, busy_o);
    chk8("ain enable", `ADCS_AIN_NO_TRIG, ain_en_o);
    ext_trigger_pin_i <= 1'b0;
    wait_busy(1'b1, 8, n);
    tick(4);
    ext_trigger_pin_i <= 1'b1;
    wait_busy(1'b0, 200, n);
    rd(`ADCS_CTRL0_OFS, 8'he2);
    rd(`ADCS_STATUS_OFS, 8'h07);
    wr(`ADCS_IRQ_CLR_OFS, 8'h07);
    // repeat runs on until stopped
    wr(`ADCS_CTRL0_OFS, {1'b1, 1'b1, 1'b0, ADCS_REPEAT, 3'h1});
    wait_busy(1'b1, 8, n);
    tick(350);
    chk1("busy", 1'b1, busy_o);
    chk8("ain enable", `ADCS_AIN_ALL, ain_en_o);
    rd(`ADCS_CTRL0_OFS, 8'hc9);
    wr(`ADCS_CTRL0_OFS, 8'h89);
    wait_busy(1'b0, 4, n);
    rd(`ADCS_STATUS_OFS, 8'h01);
    wr(`ADCS_IRQ_CLR_OFS, 8'h07);
    // single sweep over every pin count
    for (int k = 0; k < 4; k++) begin
      wr(`ADCS_CTRL1_OFS, {6'h0, k[1:0]});
      wr(`ADCS_CTRL0_OFS, {1'b1, 1'b1, 1'b0, ADCS_SINGLE_SWEEP, 3'h0});
      wait_busy(1'b1, 8, n);
      chk8("first channel", 8'h00, {5'h0, chan_o});
      mx = 3'h0;
      for (n = 0; busy_o === 1'b1; n++) begin
        if (chan_o > mx)
          mx = chan_o;
        if (n > 2000) begin
          fails++;
          $display("wrong value sweep expected end seen timeout");
          final_report();
        end
        @(posedge mclk_i);
      end
      chk8("sweep top", 8'(2 * k + 1), {5'h0, mx});
      rd(`ADCS_CTRL0_OFS, 8'h90);
    end
    // repeat sweep on two pins wraps back to input zero
    wr(`ADCS_CTRL1_OFS, 8'h00);
    wr(`ADCS_CTRL0_OFS, {1'b1, 1'b1, 1'b0, ADCS_REPEAT_SWEEP, 3'h0});
    wait_busy(1'b1, 8, n);
    for (n = 0; n < 500; n++) begin
      @(posedge mclk_i);
      if (chan_o > 3'h1)
        chk8("wrap channel", 8'h01, {5'h0, chan_o});
    end
    chk1("busy", 1'b1, busy_o);
    wr(`ADCS_CTRL0_OFS, 8'h98);
    wait_busy(1'b0, 4, n);
    wr(`ADCS_IRQ_CLR_OFS, 8'h07);
    // external single sweep over eight pins hops over input five
    wr(`ADCS_CTRL1_OFS, 8'h03);
    wr(`ADCS_CTRL0_OFS, 8'hf0);
    ext_trigger_pin_i <= 1'b0;
    wait_busy(1'b1, 8, n);
    ext_trigger_pin_i <= 1'b1;
    mx = 3'h0;
    for (n = 0; busy_o === 1'b1; n++) begin
      chk1("input five skipped", 1'b1, chan_o !== 3'h5);
      if (chan_o > mx)
        mx = chan_o;
      if (n > 2000) begin
        fails++;
        $display("wrong value ext sweep expected end seen timeout");
        final_report();
      end
      @(posedge mclk_i);
    end
    chk8("ext sweep top", 8'h07, {5'h0, mx});
    rd(`ADCS_CTRL0_OFS, 8'hf0);
    rd(`ADCS_STATUS_OFS, 8'h07);
    // external one-shot on input five runs but keeps nothing
    wr(`ADCS_IRQ_CLR_OFS, 8'h07);
    wr(`ADCS_CTRL0_OFS, 8'he5);
    ext_trigger_pin_i <= 1'b0;
    wait_busy(1'b1, 8, n);
    ext_trigger_pin_i <= 1'b1;
    wait_busy(1'b0, 200, n);
    rd(`ADCS_STATUS_OFS, 8'h06);
    wr(`ADCS_IRQ_CLR_OFS, 8'h07);
    // stop in mid one-shot: no result stored
    wr(`ADCS_CTRL0_OFS, 8'h43);
    wait_busy(1'b1, 8, n);
    tick(30);
    wr(`ADCS_CTRL0_OFS, 8'h03);
    wait_busy(1'b0, 4, n);
    tick(250);
    rd(`ADCS_STATUS_OFS, 8'h00);
    tick(4);
    chk8("pending reads", 8'h00, 8'(exp_q.size()));
    final_report();
  end

endmodule // adcs_seq_ctrl_test
